// ===== verilog/drive_out_pkg.sv
package drive_out_pkg;
    // Register indices; the port address is the index itself
    localparam logic [7:0] IDX_FM_TERMINAL_MODE = 8'h00;
    localparam logic [7:0] IDX_SWITCH_OUTPUT_FUNCTION = 8'h01;
    localparam logic [7:0] IDX_BOARD_RELAY_FUNCTION = 8'h02;
    localparam logic [7:0] IDX_EXTENSION_RELAY_FUNCTION = 8'h03;
    localparam logic [7:0] IDX_OPEN_COLLECTOR_OUT1_FUNCTION = 8'h04;
    localparam logic [7:0] IDX_EXTENSION_OUT2_FUNCTION = 8'h05;
    localparam logic [7:0] IDX_PULSE_MAX_FREQUENCY = 8'h09;
    localparam logic [7:0] IDX_PULSE_LEVEL = 8'h10;
    localparam logic [7:0] IDX_TERMINAL_STATUS = 8'h11;
    localparam logic [15:0] RST_FM_MODE = 16'h0000;
    localparam logic [15:0] RST_SWITCH_FUNC = 16'h0000;
    localparam logic [15:0] RST_BOARD_RELAY_FUNC = 16'h0002;
    localparam logic [15:0] RST_EXT_RELAY_FUNC = 16'h0000;
    localparam logic [15:0] RST_OC_OUT1_FUNC = 16'h0001;
    localparam logic [15:0] RST_EXT_OUT2_FUNC = 16'h0004;
    // Pulse max frequency in units of 0.01 kHz
    localparam logic [15:0] RST_PULSE_MAX = 16'h1388;
    localparam logic [15:0] PULSE_MAX_LIMIT = 16'h2710;
    localparam logic [15:0] PULSE_MIN_SETTING = 16'h0001;
    localparam logic [15:0] PULSE_HW_LIMIT = 16'h1388;
    localparam logic [15:0] RST_PULSE_LEVEL = 16'h0000;
    localparam logic [15:0] MODE_PULSE = 16'h0000;
    localparam logic [15:0] MODE_SWITCH = 16'h0001;
    localparam int CLK_HZ = 20000000;
    localparam int CYCLE_PULSE_MS = 250;
    localparam int CYCLE_PULSE_CYCLES = CLK_HZ / 1000 * CYCLE_PULSE_MS;
    // Half-period cycles at 0.01 kHz output unit: clk / (2 * 10 Hz * setting)
    localparam int HALF_PERIOD_NUM = CLK_HZ / 20;
    localparam int NUM_TERMINALS = 5;
    localparam int NUM_FLAGS = 19;
endpackage

// ===== verilog/drive_status_output_selector.sv
// Behaviour
// - Mode 0 pulse output, 1 switch; reset 0
// - Pulse train never exceeds 50 kHz
// - Five selectors with documented default codes
// - Code 0 keeps terminal inactive
// - Code 1 ON while running
// - Code 2 ON on fault stop
// - Codes 3,4 follow level and reached flags
// - Code 5 ON running at zero, OFF stopped
// - Code 6 motor overload pre-warning
// - Code 7 drive overload pre-warning ten seconds early
// - Codes 8,9 count targets reached
// - Code 10 length target exceeded
// - Code 11 one 250 ms pulse per cycle
// - Code 12 running time threshold exceeded
// - Code 13 frequency limited
// - Code 14 torque limited in speed mode
// - Code 15 ready for run
// - Code 16 first analog above second
// - Code 17 upper limit reached
// - Code 18 lower limit, OFF at stop
// - Pulse scaled 0.01 kHz to the lower of settable maximum and 50 kHz
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_selector #(
    parameter int CYCLE_PULSE_LEN = drive_out_pkg::CYCLE_PULSE_CYCLES
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire logic running_i,
    input wire logic fault_stop_i,
    input wire logic freq_level_detect_one_i,
    input wire logic freq_reached_i,
    input wire logic zero_freq_i,
    input wire logic motor_overload_warn_i,
    input wire logic drive_overload_warn_i,
    input wire logic set_count_reached_i,
    input wire logic designated_count_reached_i,
    input wire logic length_reached_i,
    input wire logic seq_cycle_done_i,
    input wire logic run_time_reached_i,
    input wire logic freq_limited_i,
    input wire logic torque_limited_i,
    input wire logic speed_mode_i,
    input wire logic ready_i,
    input wire logic analog_one_gt_two_i,
    input wire logic upper_limit_i,
    input wire logic lower_limit_i,
    output logic pulse_freq_output_o,
    output logic multiplexed_switch_output_o,
    output logic board_relay_o,
    output logic extension_relay_o,
    output logic open_collector_out1_o,
    output logic extension_out2_o
);
    typedef struct packed {
        logic [15:0] fm_mode;
        logic [15:0] sel0;
        logic [15:0] sel1;
        logic [15:0] sel2;
        logic [15:0] sel3;
        logic [15:0] sel4;
        logic [15:0] pulse_max;
        logic [15:0] pulse_level;
        logic [15:0] rdata;
        logic [31:0] half_cnt;
        logic pulse_out;
        logic [31:0] cyc_cnt;
        logic cyc_prev;
        logic [4:0] term;
        logic fm_pulse_pin;
        logic fm_switch_pin;
    } state_s;

    state_s st_r;
    state_s st_nxt;
    logic [18:0] flags;
    logic [4:0] term_val;
    logic [31:0] half_target;
    logic [15:0] eff_freq;

    // Condition vector indexed by function code
    always_comb begin
        flags = 19'h00000;
        flags[1] = running_i;
        flags[2] = fault_stop_i;
        flags[3] = freq_level_detect_one_i;
        flags[4] = freq_reached_i;
        flags[5] = running_i & zero_freq_i;
        flags[6] = motor_overload_warn_i;
        flags[7] = drive_overload_warn_i;
        flags[8] = set_count_reached_i;
        flags[9] = designated_count_reached_i;
        flags[10] = length_reached_i;
        flags[11] = (st_r.cyc_cnt != 32'h0);
        flags[12] = run_time_reached_i;
        flags[13] = freq_limited_i;
        flags[14] = speed_mode_i & torque_limited_i;
        flags[15] = ready_i;
        flags[16] = analog_one_gt_two_i;
        flags[17] = upper_limit_i;
        flags[18] = running_i & lower_limit_i;
    end

    function automatic logic pick(input logic [15:0] code, input logic [18:0] f);
        // Code 0 has no flag; codes past 18 stay OFF
        if (code == 16'h0000 || code > 16'h0012) begin
            pick = 1'b0;
        end else begin
            pick = f[code[4:0]];
        end
    endfunction

    always_comb begin
        term_val[0] = pick(st_r.sel0, flags);
        term_val[1] = pick(st_r.sel1, flags);
        term_val[2] = pick(st_r.sel2, flags);
        term_val[3] = pick(st_r.sel3, flags);
        term_val[4] = pick(st_r.sel4, flags);
        // Frequency from level: min + level * (max - min) / 0xffff, clamped to pin limit
        eff_freq = 16'((32'(drive_out_pkg::PULSE_MIN_SETTING) + (32'(st_r.pulse_level)
            * 32'(st_r.pulse_max - drive_out_pkg::PULSE_MIN_SETTING)) / 32'hffff));
        if (eff_freq > drive_out_pkg::PULSE_HW_LIMIT) begin
            eff_freq = drive_out_pkg::PULSE_HW_LIMIT;
        end
        if (eff_freq == 16'h0000) begin
            eff_freq = drive_out_pkg::PULSE_MIN_SETTING;
        end
        half_target = 32'(drive_out_pkg::HALF_PERIOD_NUM) / 32'(eff_freq);
    end

    always_comb begin
        st_nxt = st_r;
        if (wr_i) begin
            unique case (addr_i)
                drive_out_pkg::IDX_FM_TERMINAL_MODE: st_nxt.fm_mode = {15'h0000, wdata_i[0]};
                drive_out_pkg::IDX_SWITCH_OUTPUT_FUNCTION: st_nxt.sel0 = wdata_i;
                drive_out_pkg::IDX_BOARD_RELAY_FUNCTION: st_nxt.sel1 = wdata_i;
                drive_out_pkg::IDX_EXTENSION_RELAY_FUNCTION: st_nxt.sel2 = wdata_i;
                drive_out_pkg::IDX_OPEN_COLLECTOR_OUT1_FUNCTION: st_nxt.sel3 = wdata_i;
                drive_out_pkg::IDX_EXTENSION_OUT2_FUNCTION: st_nxt.sel4 = wdata_i;
                drive_out_pkg::IDX_PULSE_MAX_FREQUENCY: begin
                    // Out-of-range settings are dropped, keeping the old maximum
                    if (wdata_i >= drive_out_pkg::PULSE_MIN_SETTING
                        && wdata_i <= drive_out_pkg::PULSE_MAX_LIMIT) begin
                        st_nxt.pulse_max = wdata_i;
                    end
                end
                drive_out_pkg::IDX_PULSE_LEVEL: st_nxt.pulse_level = wdata_i;
                default: begin
                end
            endcase
        end
        st_nxt.rdata = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                drive_out_pkg::IDX_FM_TERMINAL_MODE: st_nxt.rdata = st_r.fm_mode;
                drive_out_pkg::IDX_SWITCH_OUTPUT_FUNCTION: st_nxt.rdata = st_r.sel0;
                drive_out_pkg::IDX_BOARD_RELAY_FUNCTION: st_nxt.rdata = st_r.sel1;
                drive_out_pkg::IDX_EXTENSION_RELAY_FUNCTION: st_nxt.rdata = st_r.sel2;
                drive_out_pkg::IDX_OPEN_COLLECTOR_OUT1_FUNCTION: st_nxt.rdata = st_r.sel3;
                drive_out_pkg::IDX_EXTENSION_OUT2_FUNCTION: st_nxt.rdata = st_r.sel4;
                drive_out_pkg::IDX_PULSE_MAX_FREQUENCY: st_nxt.rdata = st_r.pulse_max;
                drive_out_pkg::IDX_PULSE_LEVEL: st_nxt.rdata = st_r.pulse_level;
                drive_out_pkg::IDX_TERMINAL_STATUS: st_nxt.rdata = {11'h000, st_r.term};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        // Rising edge of cycle-done restarts the pulse; a retrigger just extends it
        st_nxt.cyc_prev = seq_cycle_done_i;
        if (seq_cycle_done_i && !st_r.cyc_prev) begin
            st_nxt.cyc_cnt = 32'(CYCLE_PULSE_LEN);
        end else if (st_r.cyc_cnt != 32'h0) begin
            st_nxt.cyc_cnt = st_r.cyc_cnt - 32'h1;
        end
        // Square wave generator runs free; only its pin is gated by mode
        if (st_r.half_cnt + 32'h1 >= half_target) begin
            st_nxt.half_cnt = 32'h0;
            st_nxt.pulse_out = ~st_r.pulse_out;
        end else begin
            st_nxt.half_cnt = st_r.half_cnt + 32'h1;
        end
        st_nxt.term = term_val;
        if (st_r.fm_mode == drive_out_pkg::MODE_SWITCH) begin
            st_nxt.fm_switch_pin = term_val[0];
            st_nxt.fm_pulse_pin = 1'b0;
        end else begin
            st_nxt.fm_switch_pin = 1'b0;
            st_nxt.fm_pulse_pin = st_r.pulse_out;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r <= '{
                fm_mode: drive_out_pkg::RST_FM_MODE,
                sel0: drive_out_pkg::RST_SWITCH_FUNC,
                sel1: drive_out_pkg::RST_BOARD_RELAY_FUNC,
                sel2: drive_out_pkg::RST_EXT_RELAY_FUNC,
                sel3: drive_out_pkg::RST_OC_OUT1_FUNC,
                sel4: drive_out_pkg::RST_EXT_OUT2_FUNC,
                pulse_max: drive_out_pkg::RST_PULSE_MAX,
                pulse_level: drive_out_pkg::RST_PULSE_LEVEL,
                rdata: 16'h0000,
                half_cnt: 32'h0,
                pulse_out: 1'b0,
                cyc_cnt: 32'h0,
                cyc_prev: 1'b0,
                term: 5'h00,
                fm_pulse_pin: 1'b0,
                fm_switch_pin: 1'b0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign pulse_freq_output_o = st_r.fm_pulse_pin;
    assign multiplexed_switch_output_o = st_r.fm_switch_pin;
    assign board_relay_o = st_r.term[1];
    assign extension_relay_o = st_r.term[2];
    assign open_collector_out1_o = st_r.term[3];
    assign extension_out2_o = st_r.term[4];
endmodule // drive_status_output_selector
`default_nettype wire

// ===== tb/pulse_load.sv
`timescale 1ns/1ps
`default_nettype none
module pulse_load (
    input wire logic clk_i,
    input wire logic sig_i,
    output int half_o
);
    int cnt = 0;
    logic last = 1'b0;
    initial half_o = 0;
    // Length of the last whole phase seen at the pin
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
        last <= sig_i;
        if (sig_i != last) begin
            half_o <= cnt;
            cnt <= 1;
        end
    end
endmodule // pulse_load
`default_nettype wire

// ===== tb/drive_out_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module drive_out_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic running_i,
    input wire logic fault_stop_i,
    input wire logic zero_freq_i,
    input wire logic motor_overload_warn_i,
    input wire logic torque_limited_i,
    input wire logic speed_mode_i,
    input wire logic lower_limit_i,
    input wire logic board_relay_o
);
    logic [15:0] sel_r;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Shadow of the board relay selector; checker cannot see the register
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_r <= 16'h0002;
        end else if (wr_i && addr_i == 8'h02) begin
            sel_r <= wdata_i;
        end
    end
    AST_CODE0: assert property (sel_r == 16'h0000 |=> !board_relay_o)
        else $error("code 0 drove relay");
    AST_CODE1: assert property (sel_r == 16'h0001 |=> board_relay_o == $past(running_i))
        else $error("code 1 wrong");
    AST_CODE2: assert property (sel_r == 16'h0002 |=> board_relay_o == $past(fault_stop_i))
        else $error("code 2 wrong");
    AST_CODE5: assert property (sel_r == 16'h0005 && running_i && zero_freq_i |=> board_relay_o)
        else $error("code 5 wrong");
    AST_CODE6: assert property (sel_r == 16'h0006 && !motor_overload_warn_i |=> !board_relay_o)
        else $error("code 6 wrong");
    AST_CODE14: assert property (sel_r == 16'h000e |=> board_relay_o == $past(speed_mode_i && torque_limited_i))
        else $error("code 14 wrong");
    AST_CODE18: assert property (sel_r == 16'h0012 && !running_i |=> !board_relay_o)
        else $error("code 18 on at stop");
    AST_HIGH: assert property (sel_r > 16'h0012 |=> !board_relay_o)
        else $error("unknown code drove relay");
endmodule // drive_out_assertions
`default_nettype wire

// ===== tb/drive_status_output_selector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module drive_status_output_selector_tb;
    localparam int PLEN = 20;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic [15:0] rdata_o;
    logic [18:0] st = 19'h00000;
    wire logic [4:0] term;
    logic pulse_o;
    int half;
    int n_fail = 0;
    int check_count = 0;
    drive_status_output_selector #(.CYCLE_PULSE_LEN(PLEN)) dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .running_i(st[0]), .fault_stop_i(st[1]),
        .freq_level_detect_one_i(st[2]), .freq_reached_i(st[3]), .zero_freq_i(st[4]),
        .motor_overload_warn_i(st[5]), .drive_overload_warn_i(st[6]),
        .set_count_reached_i(st[7]), .designated_count_reached_i(st[8]),
        .length_reached_i(st[9]), .seq_cycle_done_i(st[10]), .run_time_reached_i(st[11]),
        .freq_limited_i(st[12]), .torque_limited_i(st[13]), .speed_mode_i(st[14]),
        .ready_i(st[15]), .analog_one_gt_two_i(st[16]), .upper_limit_i(st[17]),
        .lower_limit_i(st[18]), .pulse_freq_output_o(pulse_o),
        .multiplexed_switch_output_o(term[0]), .board_relay_o(term[1]),
        .extension_relay_o(term[2]), .open_collector_out1_o(term[3]), .extension_out2_o(term[4])
    );
    pulse_load load_u (.clk_i(clk_i), .sig_i(pulse_o), .half_o(half));
    initial forever #25 clk_i = ~clk_i;
    function automatic logic f(input int c, input logic [18:0] v);
        case (c)
            1: f = v[0];
            2: f = v[1];
            3: f = v[2];
            4: f = v[3];
            5: f = v[0] & v[4];
            6, 7, 8, 9, 10: f = v[c - 1];
            12, 13: f = v[c - 1];
            14: f = v[13] & v[14];
            15, 16, 17: f = v[c];
            18: f = v[0] & v[18];
            default: f = 1'b0;
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(negedge clk_i);
        chk(rdata_o, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic t_defaults;
        rd(8'h00, 16'h0000);
        rd(8'h01, 16'h0000);
        rd(8'h02, 16'h0002);
        rd(8'h03, 16'h0000);
        rd(8'h04, 16'h0001);
        rd(8'h05, 16'h0004);
        rd(8'h20, 16'h0000);
        @(posedge clk_i);
        st <= 19'h0000b;
        settle(3);
        chk(term, 5'h1a);
        rd(8'h11, 16'h001a);
        settle(1);
        chk(rdata_o, 16'h0000);
    endtask
    // Same code on every terminal; mux pin needs switch mode and has the same latency
    task automatic t_codes;
        wr(8'h00, 16'h0001);
        for (int c = 0; c < 21; c++) begin
            if (c != 11) begin
                for (int i = 1; i < 6; i++) wr(8'(i), 16'(c));
                for (int v = 0; v < 21; v++) begin
                    @(posedge clk_i);
                    st <= (v == 19) ? '1 : (v == 20) ? '0 : 19'h00001 << v;
                    settle(3);
                    chk(term, {5{f(c, st)}});
                end
            end
        end
    endtask
    task automatic t_pulse;
        wr(8'h00, 16'h0000);
        wr(8'h10, 16'hffff);
        wr(8'h09, 16'h01f4);
        settle(9000);
        chk(half, 32'h7d0);
        chk(term[0], 1'b0);
        wr(8'h09, 16'h2711);
        rd(8'h09, 16'h01f4);
        wr(8'h09, 16'h0000);
        rd(8'h09, 16'h01f4);
        wr(8'h09, 16'h2710);
        settle(3000);
        chk(half, 32'hc8);
        wr(8'h00, 16'h0001);
        settle(5);
        chk(pulse_o, 1'b0);
    endtask
    task automatic t_cycle;
        int n;
        n = 0;
        wr(8'h04, 16'h000b);
        st <= '0;
        settle(3);
        @(posedge clk_i);
        st[10] <= 1'b1;
        repeat (60) begin
            @(negedge clk_i);
            n += int'(term[3]);
        end
        chk(n, PLEN);
    endtask
    task automatic close_out;
        $display("checks=%0d fails=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_fail++;
        close_out();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_defaults();
        t_codes();
        t_pulse();
        t_cycle();
        close_out();
    end
endmodule // drive_status_output_selector_tb
bind drive_status_output_selector drive_out_assertions chk_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .running_i(running_i), .fault_stop_i(fault_stop_i), .zero_freq_i(zero_freq_i),
    .motor_overload_warn_i(motor_overload_warn_i), .torque_limited_i(torque_limited_i),
    .speed_mode_i(speed_mode_i), .lower_limit_i(lower_limit_i), .board_relay_o(board_relay_o)
);
`default_nettype wire
